//--- common/ocsm_defs.vh
// register map, field positions, reset values and timing counts for ocsm
`ifndef OCSM_DEFS_VH
`define OCSM_DEFS_VH
// register byte offsets
`define OCSM_CTRL_ADDR      12'h000
`define OCSM_STATUS_ADDR    12'h004
`define OCSM_IRQ_STAT_ADDR  12'h008
`define OCSM_IRQ_MASK_ADDR  12'h00c
`define OCSM_RATE_ADDR      12'h010
`define OCSM_CSTAT_ADDR     12'h014
// control fields
`define OCSM_CTRL_SRC_OPT   0
`define OCSM_CTRL_TX_CONS   1
`define OCSM_CTRL_CS_FWD    2
`define OCSM_CTRL_RATE_LSB  4
`define OCSM_CTRL_RST       32'h0000_0010
// rate codes
`define OCSM_R_NONE         3'h0
`define OCSM_R_32K          3'h1
`define OCSM_R_44K          3'h2
`define OCSM_R_48K          3'h3
`define OCSM_R_88K          3'h4
`define OCSM_R_96K          3'h5
`define OCSM_R_176K         3'h6
`define OCSM_R_192K         3'h7
// speed modes
`define OCSM_SPD_SINGLE     2'h0
`define OCSM_SPD_DOUBLE     2'h1
`define OCSM_SPD_QUAD       2'h2
// input states
`define OCSM_IN_NOLOCK      2'h0
`define OCSM_IN_LOCK        2'h1
`define OCSM_IN_SYNC        2'h2
// interrupt bits
`define OCSM_IRQ_LOCK       0
`define OCSM_IRQ_LOSS       1
`define OCSM_IRQ_MISM       2
`define OCSM_IRQ_FMT        3
// timing
`define OCSM_CLK_MHZ        100
`define OCSM_GATE_US        100
`define OCSM_GATE_CYC       (`OCSM_GATE_US * `OCSM_CLK_MHZ)
`define OCSM_LOSS_US        40
`define OCSM_LOSS_CYC       (`OCSM_LOSS_US * `OCSM_CLK_MHZ)
`define OCSM_GOOD_FRAMES    8
`define OCSM_XTAL_DIV       32
`endif

//--- src/ocsm_clk_switch.v
// glitch-free selection between two clock enables with handover gaps
`timescale 1ns/1ps
module ocsm_clk_switch
(
    input  wire clk,
    input  wire rst_n,
    input  wire sel_ext,
    input  wire int_tick,
    input  wire ext_tick,
    output reg  tick_q,
    output reg  ext_act_q
);
    reg arm_q;

    // the new source takes over at its own tick, so its first period is
    // whole; a recovered clock may already be gone, so leaving it never
    // waits for its tick
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            tick_q    <= 1'b0;
            ext_act_q <= 1'b0;
            arm_q     <= 1'b0;
        end
        else
        begin
            tick_q <= ext_act_q ? ext_tick : int_tick;
            if (sel_ext != ext_act_q)
            begin
                if (ext_act_q || int_tick)
                    arm_q <= 1'b1;
                if (arm_q && (sel_ext ? ext_tick : int_tick))
                begin
                    ext_act_q <= sel_ext;
                    arm_q     <= 1'b0;
                end
            end
            else
                arm_q <= 1'b0;
        end
    end
endmodule // ocsm_clk_switch

//--- src/ocsm_rate_meter.v
// measures the link frame period in core cycles and reports its rate class once per fixed gate
`timescale 1ns/1ps
`include "ocsm_defs.vh"
module ocsm_rate_meter
#(
    parameter GATE_CYC = `OCSM_GATE_CYC
)
(
    input  wire       clk,
    input  wire       rst_n,
    input  wire       frame_tick,
    output reg  [2:0] rate_q,
    output reg        done_q
);
    reg [31:0] gate_q;
    reg [15:0] per_q;
    reg [2:0]  last_q;
    reg [2:0]  prev_q;
    reg        seen_q;

    // frame period in core cycles at 100 MHz, about two percent bands;
    // counting frames in a short gate cannot tell 44.1k from 48k
    function [2:0] classify;
        input [15:0] n;
        begin
            if (n >= 16'd3060 && n <= 16'd3190)
                classify = `OCSM_R_32K;
            else if (n >= 16'd2220 && n <= 16'd2315)
                classify = `OCSM_R_44K;
            else if (n >= 16'd2040 && n <= 16'd2125)
                classify = `OCSM_R_48K;
            else if (n >= 16'd1110 && n <= 16'd1157)
                classify = `OCSM_R_88K;
            else if (n >= 16'd1020 && n <= 16'd1063)
                classify = `OCSM_R_96K;
            else if (n >= 16'd555 && n <= 16'd578)
                classify = `OCSM_R_176K;
            else if (n >= 16'd510 && n <= 16'd531)
                classify = `OCSM_R_192K;
            else
                classify = `OCSM_R_NONE;
        end
    endfunction

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            gate_q <= 32'h0;
            per_q  <= 16'h0;
            last_q <= `OCSM_R_NONE;
            prev_q <= `OCSM_R_NONE;
            seen_q <= 1'b0;
            rate_q <= `OCSM_R_NONE;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (frame_tick)
            begin
                per_q  <= 16'h0;
                last_q <= classify(per_q + 16'h1);
                prev_q <= last_q;
            end
            else if (per_q != 16'hffff)
                per_q <= per_q + 16'h1;
            if (gate_q == GATE_CYC - 1)
            begin
                gate_q <= 32'h0;
                seen_q <= frame_tick;
                // a frame seen in the gate and two equal period classes in a row, else no rate
                rate_q <= (seen_q && last_q == prev_q) ?
                          last_q : `OCSM_R_NONE;
                done_q <= 1'b1;
            end
            else
            begin
                gate_q <= gate_q + 32'h1;
                if (frame_tick)
                    seen_q <= 1'b1;
            end
        end
    end
endmodule // ocsm_rate_meter

//--- src/ocsm_top.v
// optical input clock selection, status and channel mapping with apb slave
// Contract
// - with optical source chosen, scan input and use recovered clock
// - fall back to internal clock as master when input reference lost
// - report input as no lock, lock, or sync
// - measure input rate; report no lock when rate unknown
// - never report sync when input rate differs from running rate
// - flag error when stable input rate differs from configured rate
// - multiplex one channel over two or four optical channels at speed
// - 88.2/96 kHz double speed, 176.4/192 kHz quad speed
// - receive channels 1-8, 1-4 or 1-2 by speed
// - transmit channels 1-8, 1-4 or 1-2 by speed
// - auto-detect consumer format, audio into first two slots
// - setting selects tx format; consumer tx takes first two slots
// - channel status of consumer input readable when forwarding enabled
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "ocsm_defs.vh"
module ocsm_top
#(
    parameter GATE_CYC = `OCSM_GATE_CYC,
    parameter LOSS_CYC = `OCSM_LOSS_CYC
)
(
    input  wire        CORE_CLK,
    input  wire        RST_N,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    output reg         IRQ,
    input  wire        RX_FRAME_CLK,
    input  wire        RX_FRAME_OK,
    input  wire        RX_CONSUMER,
    input  wire        RX_CS_BIT,
    input  wire [7:0]  RX_SLOT_VALID,
    input  wire [7:0]  TX_SLOT_REQ,
    output reg         SAMPLE_TICK,
    output reg         CLK_EXT_ACTIVE,
    output reg         CLK_MASTER,
    output reg  [1:0]  SPEED_MODE,
    output reg  [7:0]  RX_SLOT_EN,
    output reg  [7:0]  TX_SLOT_EN,
    output reg         TX_CONSUMER,
    output reg  [1:0]  MUX_FACTOR
);
    ////////////////////////////////////////////////////////////////////////
    // link input synchronisers
    reg [1:0] fclk_s_q;
    reg       fclk_d_q;
    reg [1:0] ok_s_q;
    reg [1:0] cons_s_q;
    reg [1:0] cs_s_q;
    reg [7:0] rxv_a_q;
    reg [7:0] rxv_b_q;
    always @(posedge CORE_CLK)
    begin
        fclk_s_q <= {fclk_s_q[0], RX_FRAME_CLK};
        ok_s_q   <= {ok_s_q[0], RX_FRAME_OK};
        cons_s_q <= {cons_s_q[0], RX_CONSUMER};
        cs_s_q   <= {cs_s_q[0], RX_CS_BIT};
        rxv_a_q  <= RX_SLOT_VALID;
        rxv_b_q  <= rxv_a_q;
        fclk_d_q <= fclk_s_q[1];
    end
    wire frame_tick = fclk_s_q[1] & ~fclk_d_q;
    wire frame_ok   = ok_s_q[1];
    wire consumer   = cons_s_q[1];

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg  [31:0] ctrl_q;
    reg  [3:0]  irq_stat_q;
    reg  [3:0]  irq_mask_q;
    reg  [31:0] cstat_q;
    wire        src_opt  = ctrl_q[`OCSM_CTRL_SRC_OPT];
    wire        tx_cons  = ctrl_q[`OCSM_CTRL_TX_CONS];
    wire        cs_fwd   = ctrl_q[`OCSM_CTRL_CS_FWD];
    wire [2:0]  cfg_rate = ctrl_q[`OCSM_CTRL_RATE_LSB+2:`OCSM_CTRL_RATE_LSB];

    function [1:0] speed_of;
        input [2:0] r;
        begin
            if (r == `OCSM_R_88K || r == `OCSM_R_96K)
                speed_of = `OCSM_SPD_DOUBLE;
            else if (r == `OCSM_R_176K || r == `OCSM_R_192K)
                speed_of = `OCSM_SPD_QUAD;
            else
                speed_of = `OCSM_SPD_SINGLE;
        end
    endfunction

    function [7:0] slots_of;
        input [1:0] s;
        begin
            case (s)
                `OCSM_SPD_DOUBLE: slots_of = 8'h0f;
                `OCSM_SPD_QUAD:   slots_of = 8'h03;
                default:          slots_of = 8'hff;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // rate measurement and validity
    wire [2:0] meas_rate;
    wire       meas_done;
    ocsm_rate_meter #(.GATE_CYC(GATE_CYC)) u_meter
    (
        .clk        (CORE_CLK),
        .rst_n      (RST_N),
        .frame_tick (frame_tick),
        .rate_q     (meas_rate),
        .done_q     (meas_done)
    );

    reg [3:0]  good_q;
    reg [31:0] idle_q;
    reg        valid_q;
    reg [2:0]  in_rate_q;
    wire       lost = !frame_ok || idle_q >= LOSS_CYC;
    always @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            good_q    <= 4'h0;
            idle_q    <= 32'h0;
            valid_q   <= 1'b0;
            in_rate_q <= `OCSM_R_NONE;
        end
        else
        begin
            idle_q <= frame_tick ? 32'h0 : idle_q + {31'h0, ~lost};
            if (lost)
            begin
                good_q    <= 4'h0;
                valid_q   <= 1'b0;
                in_rate_q <= `OCSM_R_NONE;
            end
            else
            begin
                if (frame_tick && good_q != `OCSM_GOOD_FRAMES)
                    good_q <= good_q + 4'h1;
                if (meas_done)
                begin
                    in_rate_q <= meas_rate;
                    valid_q   <= good_q == `OCSM_GOOD_FRAMES &&
                                 meas_rate != `OCSM_R_NONE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock selection
    reg [4:0] xdiv_q;
    reg       int_tick_q;
    always @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            xdiv_q     <= 5'h0;
            int_tick_q <= 1'b0;
        end
        else
        begin
            xdiv_q     <= xdiv_q + 5'h1;
            int_tick_q <= xdiv_q == `OCSM_XTAL_DIV - 1;
        end
    end

    wire sel_ext = src_opt & valid_q;
    wire tick_w;
    wire ext_w;
    ocsm_clk_switch u_switch
    (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .sel_ext   (sel_ext),
        .int_tick  (int_tick_q),
        .ext_tick  (frame_tick),
        .tick_q    (tick_w),
        .ext_act_q (ext_w)
    );

    wire [2:0] run_rate = ext_w ? in_rate_q : cfg_rate;
    wire       mism     = valid_q && in_rate_q != cfg_rate;
    wire       synced   = valid_q && in_rate_q == run_rate &&
                          (ext_w || !src_opt);
    wire [1:0] in_state = !valid_q ? `OCSM_IN_NOLOCK :
                          synced ? `OCSM_IN_SYNC : `OCSM_IN_LOCK;
    wire [1:0] spd      = speed_of(run_rate);

    ////////////////////////////////////////////////////////////////////////
    // channel mapping and outputs
    reg valid_d1_q;
    reg mism_d1_q;
    reg cons_d1_q;
    always @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            SAMPLE_TICK    <= 1'b0;
            CLK_EXT_ACTIVE <= 1'b0;
            CLK_MASTER     <= 1'b1;
            SPEED_MODE     <= `OCSM_SPD_SINGLE;
            RX_SLOT_EN     <= 8'h0;
            TX_SLOT_EN     <= 8'h0;
            TX_CONSUMER    <= 1'b0;
            MUX_FACTOR     <= 2'h1;
            valid_d1_q     <= 1'b0;
            mism_d1_q      <= 1'b0;
            cons_d1_q      <= 1'b0;
            cstat_q        <= 32'h0;
        end
        else
        begin
            SAMPLE_TICK    <= tick_w;
            CLK_EXT_ACTIVE <= ext_w;
            CLK_MASTER     <= ~ext_w;
            SPEED_MODE     <= spd;
            MUX_FACTOR     <= spd == `OCSM_SPD_QUAD ? 2'h3 :
                              spd == `OCSM_SPD_DOUBLE ? 2'h2 : 2'h1;
            RX_SLOT_EN     <= !valid_q ? 8'h0 :
                              consumer ? 8'h03 :
                              slots_of(spd) & rxv_b_q;
            TX_CONSUMER    <= tx_cons;
            TX_SLOT_EN     <= (tx_cons ? 8'h03 : slots_of(spd)) &
                              TX_SLOT_REQ;
            valid_d1_q     <= valid_q;
            mism_d1_q      <= mism;
            cons_d1_q      <= consumer;
            if (cs_fwd && consumer && valid_q && frame_tick)
                cstat_q <= {cstat_q[30:0], cs_s_q[1]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave and interrupts
    wire        acc = PSEL & PENABLE & PREADY;
    wire        wr  = acc & PWRITE;
    wire [3:0]  ev  = {consumer & ~cons_d1_q, mism & ~mism_d1_q,
                       valid_d1_q & ~valid_q, valid_q & ~valid_d1_q};
    wire        hit = PADDR == `OCSM_CTRL_ADDR || PADDR == `OCSM_STATUS_ADDR ||
                      PADDR == `OCSM_IRQ_STAT_ADDR ||
                      PADDR == `OCSM_IRQ_MASK_ADDR ||
                      PADDR == `OCSM_RATE_ADDR || PADDR == `OCSM_CSTAT_ADDR;
    reg [31:0]  rd;
    always @*
    begin
        case (PADDR)
            `OCSM_CTRL_ADDR:     rd = ctrl_q;
            `OCSM_STATUS_ADDR:   rd = {24'h0, mism, consumer, ext_w,
                                       spd, 1'b0, in_state};
            `OCSM_IRQ_STAT_ADDR: rd = {28'h0, irq_stat_q};
            `OCSM_IRQ_MASK_ADDR: rd = {28'h0, irq_mask_q};
            `OCSM_RATE_ADDR:     rd = {29'h0, in_rate_q};
            `OCSM_CSTAT_ADDR:    rd = cs_fwd ? cstat_q : 32'h0;
            default:             rd = 32'h0;
        endcase
    end

    always @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            ctrl_q     <= `OCSM_CTRL_RST;
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
            PRDATA     <= 32'h0;
            PREADY     <= 1'b0;
            PSLVERR    <= 1'b0;
            IRQ        <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~hit;
            if (PSEL & PENABLE & ~PREADY)
                PRDATA <= rd;
            if (wr && PADDR == `OCSM_CTRL_ADDR)
                ctrl_q <= {25'h0, PWDATA[6:4], 1'b0, PWDATA[2:0]};
            if (wr && PADDR == `OCSM_IRQ_MASK_ADDR)
                irq_mask_q <= PWDATA[3:0];
            irq_stat_q <= (irq_stat_q &
                          ~((wr && PADDR == `OCSM_IRQ_STAT_ADDR) ?
                            PWDATA[3:0] : 4'h0)) | ev;
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule // ocsm_top

//--- tb/ocsm_link_model.sv
// far-end optical sender: frame clock, status levels, channel status bit
`timescale 1ns/1ps
module ocsm_link_model
(
    input  wire       en,
    input  wire [8:0] div,
    input  wire       ok,
    input  wire       cons,
    output reg        frame_clk,
    output wire       frame_ok,
    output wire       consumer,
    output reg        cs_bit,
    output wire [7:0] slot_valid
);
    reg       link_clk;
    reg [8:0] cnt_q;
    initial
    begin
        link_clk = 1'b0;
        frame_clk = 1'b0;
        cs_bit = 1'b0;
        cnt_q = 9'h000;
    end
    always #80 link_clk = ~link_clk;
    // frames only while sending; frame line stands low in between
    always @(posedge link_clk)
    begin
        if (!en)
        begin
            cnt_q <= 9'h000;
            frame_clk <= 1'b0;
            cs_bit <= ~cs_bit;
        end
        else
        begin
            cnt_q <= (cnt_q >= div - 9'h001) ? 9'h000 : cnt_q + 9'h001;
            frame_clk <= (cnt_q < {1'b0, div[8:1]});
            cs_bit <= 1'b1;
        end
    end
    assign frame_ok = ok;
    assign consumer = cons;
    assign slot_valid = en ? 8'hff : 8'h00;
endmodule // ocsm_link_model

//--- tb/ocsm_props.sv
// assertion checker for the optical clock selection block
`timescale 1ns/1ps
`include "ocsm_defs.vh"
module ocsm_props
#(
    parameter GATE_CYC = 1,
    parameter LOSS_CYC = 1
)
(
    input wire       CORE_CLK,
    input wire       RST_N,
    input wire       PSEL,
    input wire       PENABLE,
    input wire       PREADY,
    input wire       PSLVERR,
    input wire       RX_FRAME_OK,
    input wire       SAMPLE_TICK,
    input wire       CLK_EXT_ACTIVE,
    input wire       CLK_MASTER,
    input wire [1:0] SPEED_MODE,
    input wire [7:0] RX_SLOT_EN,
    input wire [7:0] TX_SLOT_EN,
    input wire       TX_CONSUMER,
    input wire [1:0] MUX_FACTOR
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    a_master_flag: assert property (CLK_MASTER != CLK_EXT_ACTIVE)
        else $error("master flag disagrees with clock source");
    a_tick_runt: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
        else $error("sample tick lasted two cycles");
    a_apb_wait: assert property ((PSEL && PENABLE && !$past(PENABLE))
        |=> PREADY)
        else $error("no ready one cycle into access phase");
    a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("slave error outside a completing access");
    a_quad_tx: assert property ((SPEED_MODE == `OCSM_SPD_QUAD
        && $past(SPEED_MODE, 2) == `OCSM_SPD_QUAD)
        |-> TX_SLOT_EN[7:2] == 6'h00)
        else $error("quad speed sends beyond two slots");
    a_double_rx: assert property ((SPEED_MODE == `OCSM_SPD_DOUBLE
        && $past(SPEED_MODE, 2) == `OCSM_SPD_DOUBLE)
        |-> RX_SLOT_EN[7:4] == 4'h0)
        else $error("double speed receives beyond four slots");
    a_cons_tx: assert property ((TX_CONSUMER && $past(TX_CONSUMER, 2))
        |-> TX_SLOT_EN[7:2] == 6'h00)
        else $error("consumer output uses more than two slots");
    a_mux_speed: assert property (($stable(SPEED_MODE)
        && $stable(MUX_FACTOR)) |-> MUX_FACTOR == SPEED_MODE + 2'h1)
        else $error("mux factor does not follow speed");
    a_loss_slots: assert property (!RX_FRAME_OK [*6]
        |=> RX_SLOT_EN == 8'h00)
        else $error("slots still enabled after frame failure");
endmodule // ocsm_props

bind ocsm_top ocsm_props #(.GATE_CYC(GATE_CYC), .LOSS_CYC(LOSS_CYC)) u_props
(
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_FRAME_OK(RX_FRAME_OK),
    .SAMPLE_TICK(SAMPLE_TICK), .CLK_EXT_ACTIVE(CLK_EXT_ACTIVE),
    .CLK_MASTER(CLK_MASTER), .SPEED_MODE(SPEED_MODE),
    .RX_SLOT_EN(RX_SLOT_EN), .TX_SLOT_EN(TX_SLOT_EN),
    .TX_CONSUMER(TX_CONSUMER), .MUX_FACTOR(MUX_FACTOR)
);

//--- tb/tb_top.sv
// bench for the optical clock selection block with a link model
`timescale 1ns/1ps
`include "ocsm_defs.vh"
`define CHK(g, e) \
    begin \
        checks_done = checks_done + 1; \
        if ((g) !== (e)) \
        begin \
            errors = errors + 1; \
            $display("BAD %0t got %h want %h", $time, g, e); \
        end \
    end
module tb_top;
    reg         clk;
    reg         rst_n;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    reg  [7:0]  tx_req;
    reg         lk_en;
    reg         lk_ok;
    reg         lk_cons;
    reg  [8:0]  lk_div;
    reg  [31:0] rd;
    reg         rerr;
    integer     errors;
    integer     checks_done;
    wire [31:0] prdata;
    wire        pready, pslverr, irq, tick, ext_act, master, tx_cons;
    wire        fclk, fok, fcons, fcs;
    wire [1:0]  speed, mux;
    wire [7:0]  fvalid, rx_en, tx_en;

    ocsm_top dut_u
    (
        .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
        .RX_FRAME_CLK(fclk), .RX_FRAME_OK(fok), .RX_CONSUMER(fcons),
        .RX_CS_BIT(fcs), .RX_SLOT_VALID(fvalid), .TX_SLOT_REQ(tx_req),
        .SAMPLE_TICK(tick), .CLK_EXT_ACTIVE(ext_act), .CLK_MASTER(master),
        .SPEED_MODE(speed), .RX_SLOT_EN(rx_en), .TX_SLOT_EN(tx_en),
        .TX_CONSUMER(tx_cons), .MUX_FACTOR(mux)
    );
    ocsm_link_model lm_u
    (
        .en(lk_en), .div(lk_div), .ok(lk_ok), .cons(lk_cons),
        .frame_clk(fclk), .frame_ok(fok), .consumer(fcons), .cs_bit(fcs),
        .slot_valid(fvalid)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task give_verdict;
    begin
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] wd);
        integer n;
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n = n + 1;
        end
        if (n == 20)
        begin
            errors = errors + 1;
            $display("BAD %0t no ready", $time);
            give_verdict;
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    end
    endtask
    task rdchk(input [11:0] a, input [31:0] m, input [31:0] v);
    begin
        apb(1'b0, a, 32'h0);
        `CHK(rd & m, v)
    end
    endtask
    // status polled until it shows the wanted bits, bounded
    task poll(input [31:0] m, input [31:0] v);
        integer n;
    begin
        n = 0;
        apb(1'b0, `OCSM_STATUS_ADDR, 32'h0);
        while ((rd & m) !== v && n < 400)
        begin
            repeat (100) @(posedge clk);
            apb(1'b0, `OCSM_STATUS_ADDR, 32'h0);
            n = n + 1;
        end
        `CHK(rd & m, v)
        if (n == 400)
            give_verdict;
    end
    endtask
    task link(input e, input [8:0] dv, input o, input c);
    begin
        lk_en <= e;
        lk_div <= dv;
        lk_ok <= o;
        lk_cons <= c;
    end
    endtask
    task speed_case(input [2:0] c, input [8:0] dv, input [1:0] sp,
                    input [7:0] sl);
    begin
        apb(1'b1, `OCSM_CTRL_ADDR, {25'h0, c, 4'h1});
        link(1'b1, dv, 1'b1, 1'b0);
        poll(32'h3b, {26'h0, 1'b1, sp, 3'h2});
        rdchk(`OCSM_RATE_ADDR, 32'h7, {29'h0, c});
        `CHK(speed, sp)
        `CHK(mux, sp + 2'h1)
        `CHK(rx_en, sl)
        `CHK(tx_en, sl)
        `CHK(master, 1'b0)
        $display("test speed %0d done", sp);
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        errors = 0;
        checks_done = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tx_req = 8'hff;
        lk_en = 1'b0;
        lk_ok = 1'b0;
        lk_cons = 1'b0;
        lk_div = 9'h082;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK(master, 1'b1)
        `CHK(ext_act, 1'b0)
        `CHK(irq, 1'b0)
        rdchk(`OCSM_CTRL_ADDR, 32'hffffffff, `OCSM_CTRL_RST);
        rdchk(`OCSM_RATE_ADDR, 32'hffffffff, 32'h0);
        rdchk(`OCSM_STATUS_ADDR, 32'h3, 32'h0);
        apb(1'b1, `OCSM_IRQ_MASK_ADDR, 32'hf);
        rdchk(`OCSM_IRQ_MASK_ADDR, 32'hffffffff, 32'hf);
        rdchk(12'h020, 32'hffffffff, 32'h0);
        `CHK(rerr, 1'b1)
        $display("test reset and registers done");
        speed_case(3'h3, 9'd130, 2'h0, 8'hff);
        `CHK(irq, 1'b1)
        rdchk(`OCSM_IRQ_STAT_ADDR, 32'h1, 32'h1);
        apb(1'b1, `OCSM_IRQ_MASK_ADDR, 32'h0);
        @(posedge clk);
        `CHK(irq, 1'b0)
        apb(1'b1, `OCSM_IRQ_STAT_ADDR, 32'h1);
        rdchk(`OCSM_IRQ_STAT_ADDR, 32'h1, 32'h0);
        apb(1'b1, `OCSM_IRQ_MASK_ADDR, 32'hf);
        speed_case(3'h5, 9'd65, 2'h1, 8'h0f);
        speed_case(3'h7, 9'd33, 2'h2, 8'h03);
        link(1'b0, 9'd33, 1'b0, 1'b0);
        poll(32'h23, 32'h0);
        `CHK(master, 1'b1)
        `CHK(rx_en, 8'h00)
        rdchk(`OCSM_RATE_ADDR, 32'h7, 32'h0);
        rdchk(`OCSM_IRQ_STAT_ADDR, 32'h2, 32'h2);
        apb(1'b1, `OCSM_IRQ_STAT_ADDR, 32'hf);
        @(posedge clk);
        `CHK(irq, 1'b0)
        $display("test loss done");
        apb(1'b1, `OCSM_CTRL_ADDR, 32'h26);
        link(1'b1, 9'd195, 1'b1, 1'b1);
        poll(32'hc3, 32'hc1);
        rdchk(`OCSM_RATE_ADDR, 32'h7, 32'h1);
        rdchk(`OCSM_IRQ_STAT_ADDR, 32'hc, 32'hc);
        `CHK(ext_act, 1'b0)
        `CHK(rx_en, 8'h03)
        `CHK(tx_cons, 1'b1)
        `CHK(tx_en, 8'h03)
        repeat (7000) @(posedge clk);
        rdchk(`OCSM_CSTAT_ADDR, 32'h3, 32'h3);
        apb(1'b1, `OCSM_CTRL_ADDR, 32'h22);
        rdchk(`OCSM_CSTAT_ADDR, 32'hffffffff, 32'h0);
        $display("test mismatch and consumer done");
        give_verdict;
    end
endmodule // tb_top
